// ### design/rsv_rail_ctrl.v
// Rail turn-on/turn-off sequencing and reference setpoint for a buck rail.
// Assumes a command front end on mclk_i, a vin code and vout samples on mclk_i,
// and an asynchronous enable pin.
`include "rsv_defines.vh"

module rsv_rail_ctrl #(
  parameter TICK_CYCLES = `RSV_TICK_CYCLES
) (
  input  wire        mclk_i,
  input  wire        rst_i,
  input  wire        external_enable_pin_i,
  input  wire [15:0] vin_level_i,
  input  wire        vout_sample_vld_i,
  input  wire [15:0] vout_sample_i,
  input  wire        cmd_wr_i,
  input  wire        cmd_rd_i,
  input  wire [7:0]  cmd_code_i,
  input  wire [15:0] cmd_wdata_i,
  output reg  [15:0] cmd_rdata_o,
  output reg         cmd_ack_o,
  output reg         cmd_err_o,
  output reg         regulate_en_o,
  output reg  [11:0] error_amp_reference_o
);

  localparam [3:0] ST_OFF  = 4'b0001;
  localparam [3:0] ST_TON  = 4'b0010;
  localparam [3:0] ST_ON   = 4'b0100;
  localparam [3:0] ST_TOFF = 4'b1000;

  // Limits a value into [lo, hi]
  function [15:0] clamp16;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      if (v < lo)
        clamp16 = lo;
      else if (v > hi)
        clamp16 = hi;
      else
        clamp16 = v;
    end
  endfunction

  reg [7:0]  run_control_reg;
  reg [7:0]  gating_config_reg;
  reg [15:0] output_target_reg;
  reg [15:0] output_voltage_upper_limit_reg;
  reg [15:0] output_voltage_lower_limit_reg;
  reg [1:0]  feedback_divider_scale_reg;
  reg [15:0] input_turn_on_threshold_reg;
  reg [15:0] input_turn_off_threshold_reg;
  reg [15:0] on_delay_reg;
  reg [15:0] off_delay_reg;
  reg [6:0]  fine_trim_reg;
  reg [6:0]  margin_up_reg;
  reg [6:0]  margin_dn_reg;
  reg [1:0]  target_status_reg;
  reg        pin_meta_reg;
  reg        pin_sync_reg;
  reg        vin_ok_reg;
  reg [3:0]  state_reg;
  reg [3:0]  state_next;
  reg [15:0] ms_cnt_reg;
  reg [15:0] tick_div_reg;
  reg        ms_tick_reg;
  wire [15:0] vout_avg;

  // Telemetry averaging lives apart so its depth can change alone
  rsv_vout_avg rsv_vout_avg_i (
    .mclk_i       (mclk_i),
    .rst_i        (rst_i),
    .sample_vld_i (vout_sample_vld_i),
    .sample_i     (vout_sample_i),
    .avg_o        (vout_avg)
  );

  // Target window for the current divider scale
  reg [15:0] tgt_min;
  reg [15:0] tgt_max;
  always @* begin
    if (feedback_divider_scale_reg == `RSV_SCALE_HALF) begin
      tgt_min = `RSV_TGT_HALF_MIN;
      tgt_max = `RSV_TGT_HALF_MAX;
    end else if (feedback_divider_scale_reg == `RSV_SCALE_QUARTER) begin
      tgt_min = `RSV_TGT_QTR_MIN;
      tgt_max = `RSV_TGT_QTR_MAX;
    end else begin
      tgt_min = `RSV_TGT_FULL_MIN;
      tgt_max = `RSV_TGT_FULL_MAX;
    end
  end

  wire is_write = cmd_wr_i;
  wire tgt_in_window = (cmd_wdata_i >= tgt_min) && (cmd_wdata_i <= tgt_max);
  wire tgt_high = cmd_wdata_i > output_voltage_upper_limit_reg;
  wire tgt_low  = cmd_wdata_i < output_voltage_lower_limit_reg;
  wire wr_tgt   = is_write && (cmd_code_i == `RSV_CMD_OUTPUT_TARGET) && tgt_in_window;
  wire wr_stat  = is_write && (cmd_code_i == `RSV_CMD_TARGET_STATUS);

  // Command decode; an out-of-window target or unknown code is refused whole
  reg wr_known;
  always @* begin
    if (cmd_code_i == `RSV_CMD_OUTPUT_TARGET)
      wr_known = tgt_in_window;
    else if (cmd_code_i == `RSV_CMD_RUN_CONTROL || cmd_code_i == `RSV_CMD_GATING_CONFIG ||
             cmd_code_i == `RSV_CMD_UPPER_LIMIT || cmd_code_i == `RSV_CMD_LOWER_LIMIT ||
             cmd_code_i == `RSV_CMD_DIVIDER_SCALE || cmd_code_i == `RSV_CMD_VIN_TURN_ON ||
             cmd_code_i == `RSV_CMD_VIN_TURN_OFF || cmd_code_i == `RSV_CMD_ON_DELAY ||
             cmd_code_i == `RSV_CMD_OFF_DELAY || cmd_code_i == `RSV_CMD_TARGET_STATUS ||
             cmd_code_i == `RSV_CMD_FINE_TRIM || cmd_code_i == `RSV_CMD_MARGIN_UP_STEP ||
             cmd_code_i == `RSV_CMD_MARGIN_DN_STEP)
      wr_known = 1'b1;
    else
      wr_known = 1'b0;
  end

  // Configuration writes
  always @(posedge mclk_i) begin
    if (rst_i) begin
      run_control_reg                <= `RSV_RST_RUN_CONTROL;
      gating_config_reg              <= `RSV_RST_GATING_CONFIG;
      output_target_reg              <= `RSV_RST_OUTPUT_TARGET;
      output_voltage_upper_limit_reg <= `RSV_RST_UPPER_LIMIT;
      output_voltage_lower_limit_reg <= `RSV_RST_LOWER_LIMIT;
      feedback_divider_scale_reg     <= `RSV_SCALE_FULL;
      input_turn_on_threshold_reg    <= `RSV_RST_VIN_TURN_ON;
      input_turn_off_threshold_reg   <= `RSV_RST_VIN_TURN_OFF;
      on_delay_reg                   <= `RSV_RST_DELAY;
      off_delay_reg                  <= `RSV_RST_DELAY;
      fine_trim_reg                  <= 7'h00;
      margin_up_reg                  <= 7'h00;
      margin_dn_reg                  <= 7'h00;
    end else if (is_write) begin
      if (cmd_code_i == `RSV_CMD_RUN_CONTROL)
        run_control_reg <= cmd_wdata_i[7:0];
      else if (cmd_code_i == `RSV_CMD_GATING_CONFIG)
        gating_config_reg <= cmd_wdata_i[7:0];
      else if (wr_tgt)
        output_target_reg <= clamp16(cmd_wdata_i, output_voltage_lower_limit_reg,
                                     output_voltage_upper_limit_reg);
      else if (cmd_code_i == `RSV_CMD_UPPER_LIMIT)
        output_voltage_upper_limit_reg <= cmd_wdata_i;
      else if (cmd_code_i == `RSV_CMD_LOWER_LIMIT)
        output_voltage_lower_limit_reg <= cmd_wdata_i;
      else if (cmd_code_i == `RSV_CMD_DIVIDER_SCALE)
        feedback_divider_scale_reg <= (cmd_wdata_i[1:0] == 2'h3) ? `RSV_SCALE_QUARTER
                                                                  : cmd_wdata_i[1:0];
      else if (cmd_code_i == `RSV_CMD_VIN_TURN_ON)
        input_turn_on_threshold_reg <= clamp16(cmd_wdata_i, 16'h0000,
                                               `RSV_INPUT_TURN_ON_THRESHOLD_CEIL);
      else if (cmd_code_i == `RSV_CMD_VIN_TURN_OFF)
        input_turn_off_threshold_reg <= clamp16(cmd_wdata_i, `RSV_INPUT_TURN_OFF_THRESHOLD_FLOOR,
                                                16'hFFFF);
      else if (cmd_code_i == `RSV_CMD_ON_DELAY)
        on_delay_reg <= clamp16(cmd_wdata_i, 16'h0000, `RSV_DELAY_MAX_MS);
      else if (cmd_code_i == `RSV_CMD_OFF_DELAY)
        off_delay_reg <= clamp16(cmd_wdata_i, 16'h0000, `RSV_DELAY_MAX_MS);
      else if (cmd_code_i == `RSV_CMD_FINE_TRIM)
        fine_trim_reg <= cmd_wdata_i[6:0];
      else if (cmd_code_i == `RSV_CMD_MARGIN_UP_STEP)
        margin_up_reg <= cmd_wdata_i[6:0];
      else if (cmd_code_i == `RSV_CMD_MARGIN_DN_STEP)
        margin_dn_reg <= cmd_wdata_i[6:0];
    end
  end

  // Clamp status: write one to clear, but a new clamp in the same cycle wins
  always @(posedge mclk_i) begin
    if (rst_i) begin
      target_status_reg <= 2'h0;
    end else begin
      target_status_reg[`RSV_STAT_HIGH_CLAMP_BIT] <= (wr_tgt && tgt_high) ||
        (target_status_reg[`RSV_STAT_HIGH_CLAMP_BIT] &&
         !(wr_stat && cmd_wdata_i[`RSV_STAT_HIGH_CLAMP_BIT]));
      target_status_reg[`RSV_STAT_LOW_CLAMP_BIT] <= (wr_tgt && tgt_low) ||
        (target_status_reg[`RSV_STAT_LOW_CLAMP_BIT] &&
         !(wr_stat && cmd_wdata_i[`RSV_STAT_LOW_CLAMP_BIT]));
    end
  end

  // Read mux and one-cycle acknowledge
  reg [15:0] rd_mux;
  reg        rd_known;
  always @* begin
    rd_known = 1'b1;
    if (cmd_code_i == `RSV_CMD_RUN_CONTROL)
      rd_mux = {8'h00, run_control_reg};
    else if (cmd_code_i == `RSV_CMD_GATING_CONFIG)
      rd_mux = {8'h00, gating_config_reg};
    else if (cmd_code_i == `RSV_CMD_OUTPUT_TARGET)
      rd_mux = output_target_reg;
    else if (cmd_code_i == `RSV_CMD_UPPER_LIMIT)
      rd_mux = output_voltage_upper_limit_reg;
    else if (cmd_code_i == `RSV_CMD_LOWER_LIMIT)
      rd_mux = output_voltage_lower_limit_reg;
    else if (cmd_code_i == `RSV_CMD_DIVIDER_SCALE)
      rd_mux = {14'h0000, feedback_divider_scale_reg};
    else if (cmd_code_i == `RSV_CMD_VIN_TURN_ON)
      rd_mux = input_turn_on_threshold_reg;
    else if (cmd_code_i == `RSV_CMD_VIN_TURN_OFF)
      rd_mux = input_turn_off_threshold_reg;
    else if (cmd_code_i == `RSV_CMD_ON_DELAY)
      rd_mux = on_delay_reg;
    else if (cmd_code_i == `RSV_CMD_OFF_DELAY)
      rd_mux = off_delay_reg;
    else if (cmd_code_i == `RSV_CMD_TARGET_STATUS)
      rd_mux = {14'h0000, target_status_reg};
    else if (cmd_code_i == `RSV_CMD_OUTPUT_MEASURE)
      rd_mux = vout_avg;
    else if (cmd_code_i == `RSV_CMD_FINE_TRIM)
      rd_mux = {{9{fine_trim_reg[6]}}, fine_trim_reg};
    else if (cmd_code_i == `RSV_CMD_MARGIN_UP_STEP)
      rd_mux = {{9{margin_up_reg[6]}}, margin_up_reg};
    else if (cmd_code_i == `RSV_CMD_MARGIN_DN_STEP)
      rd_mux = {{9{margin_dn_reg[6]}}, margin_dn_reg};
    else begin
      rd_mux   = 16'h0000;
      rd_known = 1'b0;
    end
  end

  always @(posedge mclk_i) begin
    if (rst_i) begin
      cmd_rdata_o <= 16'h0000;
      cmd_ack_o   <= 1'b0;
      cmd_err_o   <= 1'b0;
    end else begin
      cmd_ack_o <= cmd_wr_i || cmd_rd_i;
      cmd_err_o <= (cmd_wr_i && !wr_known) || (cmd_rd_i && !cmd_wr_i && !rd_known);
      if (cmd_rd_i && !cmd_wr_i)
        cmd_rdata_o <= rd_mux;
    end
  end

  // Pin synchroniser and input lockout with hysteresis
  always @(posedge mclk_i) begin
    if (rst_i) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
      vin_ok_reg   <= 1'b0;
    end else begin
      pin_meta_reg <= external_enable_pin_i;
      pin_sync_reg <= pin_meta_reg;
      if (vin_level_i >= input_turn_on_threshold_reg)
        vin_ok_reg <= 1'b1;
      else if (vin_level_i < input_turn_off_threshold_reg)
        vin_ok_reg <= 1'b0;
    end
  end

  // Every selected source must hold; lockout is always among them
  wire pin_on = (pin_sync_reg == gating_config_reg[`RSV_GATE_PIN_HIGH_BIT]);
  wire gate_on = vin_ok_reg &&
    (!gating_config_reg[`RSV_GATE_USE_PIN_BIT] || pin_on) &&
    (!gating_config_reg[`RSV_GATE_USE_CMD_BIT] ||
     run_control_reg[`RSV_RUN_ON_BIT]);

  // Millisecond tick; counting whole ms keeps the delay counter narrow
  always @(posedge mclk_i) begin
    if (rst_i) begin
      tick_div_reg <= 16'h0000;
      ms_tick_reg  <= 1'b0;
    end else if (tick_div_reg == TICK_CYCLES[15:0] - 16'h0001) begin
      tick_div_reg <= 16'h0000;
      ms_tick_reg  <= 1'b1;
    end else begin
      tick_div_reg <= tick_div_reg + 16'h0001;
      ms_tick_reg  <= 1'b0;
    end
  end

  // Sequencer
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF:  if (gate_on) state_next = ST_TON;
      ST_TON:  if (!gate_on) state_next = ST_OFF;
               else if (ms_cnt_reg >= on_delay_reg) state_next = ST_ON;
      ST_ON:   if (!gate_on) state_next = ST_TOFF;
      ST_TOFF: if (gate_on) state_next = ST_ON;
               else if (ms_cnt_reg >= off_delay_reg) state_next = ST_OFF;
      default: state_next = ST_OFF;
    endcase
  end

  always @(posedge mclk_i) begin
    if (rst_i) begin
      state_reg     <= ST_OFF;
      ms_cnt_reg    <= 16'h0000;
      regulate_en_o <= 1'b0;
    end else begin
      state_reg     <= state_next;
      regulate_en_o <= (state_next == ST_ON) || (state_next == ST_TOFF);
      if (state_next != state_reg)
        ms_cnt_reg <= 16'h0000;
      else if (ms_tick_reg && ms_cnt_reg != `RSV_DELAY_MAX_MS)
        ms_cnt_reg <= ms_cnt_reg + 16'h0001;
    end
  end

  // Reference code: scaled target plus trim plus margin, held in the DAC window
  reg [15:0] scaled;
  always @* begin
    if (feedback_divider_scale_reg == `RSV_SCALE_HALF)
      scaled = {1'b0, output_target_reg[15:1]};
    else if (feedback_divider_scale_reg == `RSV_SCALE_QUARTER)
      scaled = {2'b00, output_target_reg[15:2]};
    else
      scaled = output_target_reg;
  end

  wire [13:0] trim_x = {{7{fine_trim_reg[6]}}, fine_trim_reg};
  wire [13:0] up_x = run_control_reg[`RSV_RUN_MARGIN_UP_BIT] ?
                     {{7{margin_up_reg[6]}}, margin_up_reg} : 14'h0000;
  wire [13:0] dn_x = run_control_reg[`RSV_RUN_MARGIN_DN_BIT] ?
                     {{7{margin_dn_reg[6]}}, margin_dn_reg} : 14'h0000;
  wire [13:0] ref_sum = scaled[13:0] + trim_x + up_x + dn_x;
  // DAC bounds kept at sum width; the output takes their low twelve bits
  wire [13:0] ref_min_w = `RSV_REF_MIN;
  wire [13:0] ref_max_w = `RSV_REF_MAX;

  always @(posedge mclk_i) begin
    if (rst_i)
      error_amp_reference_o <= ref_min_w[11:0];
    else if (ref_sum[13] || ref_sum < ref_min_w)
      error_amp_reference_o <= ref_min_w[11:0];
    else if (ref_sum > ref_max_w)
      error_amp_reference_o <= ref_max_w[11:0];
    else
      error_amp_reference_o <= ref_sum[11:0];
  end

endmodule

// ### include/rsv_defines.vh
// Constants for the rail sequencer and output setpoint block.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef RSV_DEFINES_VH
`define RSV_DEFINES_VH

// Command codes on the command port
`define RSV_CMD_RUN_CONTROL      8'h01
`define RSV_CMD_GATING_CONFIG    8'h02
`define RSV_CMD_OUTPUT_TARGET    8'h21
`define RSV_CMD_UPPER_LIMIT      8'h24
`define RSV_CMD_LOWER_LIMIT      8'h28
`define RSV_CMD_DIVIDER_SCALE    8'h29
`define RSV_CMD_VIN_TURN_ON      8'h35
`define RSV_CMD_VIN_TURN_OFF     8'h36
`define RSV_CMD_ON_DELAY         8'h60
`define RSV_CMD_OFF_DELAY        8'h64
`define RSV_CMD_TARGET_STATUS    8'h7A
`define RSV_CMD_OUTPUT_MEASURE   8'h8B
`define RSV_CMD_FINE_TRIM        8'hD4
`define RSV_CMD_MARGIN_UP_STEP   8'hD5
`define RSV_CMD_MARGIN_DN_STEP   8'hD6

// Field positions
`define RSV_RUN_ON_BIT           7
`define RSV_RUN_MARGIN_UP_BIT    5
`define RSV_RUN_MARGIN_DN_BIT    4
`define RSV_GATE_USE_CMD_BIT     3
`define RSV_GATE_USE_PIN_BIT     2
`define RSV_GATE_PIN_HIGH_BIT    1
`define RSV_STAT_HIGH_CLAMP_BIT  1
`define RSV_STAT_LOW_CLAMP_BIT   0

// Divider scale encodings
`define RSV_SCALE_FULL           2'h0
`define RSV_SCALE_HALF           2'h1
`define RSV_SCALE_QUARTER        2'h2

// Accepted target windows per scale, in 1.953 mV steps
`define RSV_TGT_FULL_MIN         16'h00B3
`define RSV_TGT_FULL_MAX         16'h034D
`define RSV_TGT_HALF_MIN         16'h0166
`define RSV_TGT_HALF_MAX         16'h069A
`define RSV_TGT_QTR_MIN          16'h02CC
`define RSV_TGT_QTR_MAX          16'h0B00

// Reference DAC window: 350 mV to 1650 mV in 1.953 mV steps
`define RSV_REF_MIN              14'h00B3
`define RSV_REF_MAX              14'h034D

// Input lockout bounds, in 0.25 V steps: 4 V and 7.75 V
`define RSV_INPUT_TURN_OFF_THRESHOLD_FLOOR        16'h0010
`define RSV_INPUT_TURN_ON_THRESHOLD_CEIL          16'h001F

// Delays in ms, at most 100 ms
`define RSV_DELAY_MAX_MS         16'h0064
`define RSV_CLK_HZ               20000000
`define RSV_TICK_TIME_US         1000
`define RSV_TICK_CYCLES          ((`RSV_CLK_HZ / 1000000) * `RSV_TICK_TIME_US)

// Reset values
`define RSV_RST_RUN_CONTROL      8'h00
`define RSV_RST_GATING_CONFIG    8'h00
`define RSV_RST_OUTPUT_TARGET    16'h0200
`define RSV_RST_UPPER_LIMIT      16'h034D
`define RSV_RST_LOWER_LIMIT      16'h00B3
`define RSV_RST_VIN_TURN_ON      16'h0012
`define RSV_RST_VIN_TURN_OFF     16'h0011
`define RSV_RST_DELAY            16'h0000

// Telemetry averaging: 2^4 samples
`define RSV_AVG_LOG2             4
`define RSV_AVG_CNT_MAX          4'hF

`endif

// ### design/rsv_vout_avg.v
// Averages output-voltage samples in blocks of sixteen.
// Assumes samples arrive on mclk_i with a one-cycle valid strobe.
`include "rsv_defines.vh"

module rsv_vout_avg (
  input  wire        mclk_i,
  input  wire        rst_i,
  input  wire        sample_vld_i,
  input  wire [15:0] sample_i,
  output reg  [15:0] avg_o
);

  reg [19:0] acc_reg;
  reg [3:0]  cnt_reg;
  wire [19:0] acc_sum = acc_reg + {4'h0, sample_i};

  // Block average; a power-of-two depth keeps the divide a plain shift
  always @(posedge mclk_i) begin
    if (rst_i) begin
      acc_reg <= 20'h00000;
      cnt_reg <= 4'h0;
      avg_o   <= 16'h0000;
    end else if (sample_vld_i) begin
      cnt_reg <= cnt_reg + 4'h1;
      if (cnt_reg == `RSV_AVG_CNT_MAX) begin
        avg_o   <= acc_sum[19:`RSV_AVG_LOG2];
        acc_reg <= 20'h00000;
      end else begin
        acc_reg <= acc_sum;
      end
    end
  end

endmodule

// ### sim/rsv_rail_ctrl_sva.sv
// Port-level checker for the rail sequencer and setpoint block.
// Assumes it is bound onto rsv_rail_ctrl and sees only its ports.
module rsv_rail_ctrl_sva #(
  parameter int TICK_CYCLES = 20000
) (
  input wire logic        mclk_i,
  input wire logic        rst_i,
  input wire logic        external_enable_pin_i,
  input wire logic [15:0] vin_level_i,
  input wire logic        cmd_wr_i,
  input wire logic        cmd_rd_i,
  input wire logic [7:0]  cmd_code_i,
  input wire logic [15:0] cmd_wdata_i,
  input wire logic [15:0] cmd_rdata_o,
  input wire logic        cmd_ack_o,
  input wire logic        cmd_err_o,
  input wire logic        regulate_en_o,
  input wire logic [11:0] error_amp_reference_o
);
  timeunit 1ns;
  timeprecision 1ps;

  int unsigned low_cnt;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // Cycles spent regulating while input sits below every legal off threshold
  always_ff @(posedge mclk_i) begin
    if (rst_i || !regulate_en_o || vin_level_i >= 16'h0010) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= low_cnt + 1;
    end
  end

  chk_ack_follows: assert property ((cmd_wr_i || cmd_rd_i) |=> cmd_ack_o)
    else $error("command not acknowledged next cycle");
  chk_ack_cause: assert property (cmd_ack_o |-> $past(cmd_wr_i || cmd_rd_i))
    else $error("acknowledge without request");
  chk_err_with_ack: assert property (cmd_err_o |-> cmd_ack_o)
    else $error("refusal without acknowledge");
  chk_rdata_holds: assert property (!cmd_rd_i |=> $stable(cmd_rdata_o))
    else $error("read data moved without a read");
  chk_ref_window: assert property (error_amp_reference_o >= 12'h0B3
    && error_amp_reference_o <= 12'h34D) else $error("reference outside window");
  chk_measure_readonly: assert property ((cmd_wr_i && cmd_code_i == 8'h8B)
    |=> cmd_err_o) else $error("measurement write not refused");
  chk_low_target_err: assert property ((cmd_wr_i && cmd_code_i == 8'h21
    && cmd_wdata_i < 16'h00B3) |=> cmd_err_o) else $error("low target not refused");
  chk_ref_cause: assert property ($changed(error_amp_reference_o) |->
    $past(cmd_wr_i, 2) || $past(rst_i) || $past(rst_i, 2))
    else $error("reference moved without a write");
  chk_off_bound: assert property (low_cnt <= 101 * TICK_CYCLES + 4)
    else $error("rail kept on past longest off delay");

  cover property ($rose(regulate_en_o));
  cover property ($fell(regulate_en_o));
  cover property (cmd_err_o);
endmodule

bind rsv_rail_ctrl rsv_rail_ctrl_sva #(.TICK_CYCLES(TICK_CYCLES)) rsv_rail_ctrl_sva_i (
  .mclk_i(mclk_i), .rst_i(rst_i), .external_enable_pin_i(external_enable_pin_i),
  .vin_level_i(vin_level_i), .cmd_wr_i(cmd_wr_i), .cmd_rd_i(cmd_rd_i),
  .cmd_code_i(cmd_code_i), .cmd_wdata_i(cmd_wdata_i), .cmd_rdata_o(cmd_rdata_o),
  .cmd_ack_o(cmd_ack_o), .cmd_err_o(cmd_err_o), .regulate_en_o(regulate_en_o),
  .error_amp_reference_o(error_amp_reference_o));

// ### sim/rsv_host_model.sv
// Command host model: issues one write or read at a time.
// Assumes a one-cycle strobe and an acknowledge one cycle later.
module rsv_host_model (
  input  wire logic        mclk_i,
  input  wire logic [15:0] cmd_rdata_i,
  input  wire logic        cmd_ack_i,
  input  wire logic        cmd_err_i,
  output logic             cmd_wr_o,
  output logic             cmd_rd_o,
  output logic [7:0]       cmd_code_o,
  output logic [15:0]      cmd_wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cmd_wr_o = 1'b0;
    cmd_rd_o = 1'b0;
    cmd_code_o = 8'h00;
    cmd_wdata_o = 16'h0000;
  end

  // Idle code and data are inverted so a stale value is never mistaken for fresh
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic [15:0] q, output logic e, output logic a);
    @(negedge mclk_i);
    cmd_wr_o = w;
    cmd_rd_o = !w;
    cmd_code_o = c;
    cmd_wdata_o = d;
    @(negedge mclk_i);
    cmd_wr_o = 1'b0;
    cmd_rd_o = 1'b0;
    cmd_code_o = ~c;
    cmd_wdata_o = ~d;
    q = cmd_rdata_i;
    e = cmd_err_i;
    a = cmd_ack_i;
  endtask
endmodule

// ### sim/rsv_rail_ctrl_bench.sv
// Self-checking bench for rsv_rail_ctrl with a short millisecond tick.
// Assumes the host model drives the command port; the bench drives the rest.
module rsv_rail_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [7:0]  c;
    logic [15:0] d;
    logic        e;
    logic [15:0] rb;
  } rsv_row_t;

  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        pin = 1'b0;
  logic [15:0] vin = 16'h0000;
  logic        svld = 1'b0;
  logic [15:0] smp = 16'h0000;
  logic        wr, rd, ack, err, reg_en, re;
  logic [7:0]  code;
  logic [15:0] wd, rdat, rv;
  logic [11:0] ref_o;
  int          err_total = 0;
  int          total_checks = 0;

  // Write, expected refusal, expected readback
  rsv_row_t rows [31] = '{
    '{8'h21, 16'h0258, 1'b0, 16'h0258}, '{8'h21, 16'h0064, 1'b1, 16'h0258},
    '{8'h29, 16'h0001, 1'b0, 16'h0001}, '{8'h24, 16'h069A, 1'b0, 16'h069A},
    '{8'h21, 16'h069A, 1'b0, 16'h069A}, '{8'h21, 16'h069B, 1'b1, 16'h069A},
    '{8'h29, 16'h0002, 1'b0, 16'h0002}, '{8'h24, 16'h0B00, 1'b0, 16'h0B00},
    '{8'h29, 16'h0003, 1'b0, 16'h0002},
    '{8'h21, 16'h02CC, 1'b0, 16'h02CC}, '{8'h21, 16'h02CB, 1'b1, 16'h02CC},
    '{8'h29, 16'h0000, 1'b0, 16'h0000}, '{8'h24, 16'h02BC, 1'b0, 16'h02BC},
    '{8'h21, 16'h034D, 1'b0, 16'h02BC}, '{8'h7A, 16'h0000, 1'b0, 16'h0002},
    '{8'h7A, 16'h0002, 1'b0, 16'h0000}, '{8'h28, 16'h012C, 1'b0, 16'h012C},
    '{8'h21, 16'h00C8, 1'b0, 16'h012C}, '{8'h7A, 16'h0000, 1'b0, 16'h0001},
    '{8'h35, 16'h0028, 1'b0, 16'h001F}, '{8'h36, 16'h0005, 1'b0, 16'h0010},
    '{8'h35, 16'h0012, 1'b0, 16'h0012}, '{8'h36, 16'h0011, 1'b0, 16'h0011},
    '{8'h60, 16'h00C8, 1'b0, 16'h0064}, '{8'h60, 16'h0003, 1'b0, 16'h0003},
    '{8'h64, 16'h0002, 1'b0, 16'h0002}, '{8'hD4, 16'hFFC0, 1'b0, 16'hFFC0},
    '{8'h33, 16'h0000, 1'b1, 16'h0000}, '{8'h28, 16'h00B3, 1'b0, 16'h00B3},
    '{8'h24, 16'h034D, 1'b0, 16'h034D}, '{8'h21, 16'h0258, 1'b0, 16'h0258}};
  // Write, then expected reference code
  rsv_row_t refs [11] = '{
    '{8'hD5, 16'h000A, 1'b0, 16'h0218}, '{8'hD6, 16'h007B, 1'b0, 16'h0218},
    '{8'h01, 16'h0020, 1'b0, 16'h0222}, '{8'h01, 16'h0010, 1'b0, 16'h0213},
    '{8'h01, 16'h0030, 1'b0, 16'h021D}, '{8'h01, 16'h0000, 1'b0, 16'h0218},
    '{8'hD4, 16'h003F, 1'b0, 16'h0297}, '{8'h21, 16'h034D, 1'b0, 16'h034D},
    '{8'hD4, 16'hFFC0, 1'b0, 16'h030D}, '{8'h21, 16'h00B3, 1'b0, 16'h00B3},
    '{8'h21, 16'h0258, 1'b0, 16'h0218}};

  always #25 mclk_i = ~mclk_i;

  rsv_rail_ctrl #(.TICK_CYCLES(10)) rsv_rail_ctrl_i (
    .mclk_i(mclk_i), .rst_i(rst_i), .external_enable_pin_i(pin), .vin_level_i(vin),
    .vout_sample_vld_i(svld), .vout_sample_i(smp), .cmd_wr_i(wr), .cmd_rd_i(rd),
    .cmd_code_i(code), .cmd_wdata_i(wd), .cmd_rdata_o(rdat), .cmd_ack_o(ack),
    .cmd_err_o(err), .regulate_en_o(reg_en), .error_amp_reference_o(ref_o));

  rsv_host_model rsv_host_model_i (
    .mclk_i(mclk_i), .cmd_rdata_i(rdat), .cmd_ack_i(ack), .cmd_err_i(err),
    .cmd_wr_o(wr), .cmd_rd_o(rd), .cmd_code_o(code), .cmd_wdata_o(wd));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wr_cmd(input logic [7:0] c, input logic [15:0] d, output logic e);
    logic [15:0] q;
    logic        a;
    rsv_host_model_i.xfer(1'b1, c, d, q, e, a);
    chk({15'h0000, a}, 16'h0001, "write ack");
  endtask

  task automatic rd_cmd(input logic [7:0] c, output logic [15:0] q);
    logic e;
    logic a;
    rsv_host_model_i.xfer(1'b0, c, 16'h0000, q, e, a);
    chk({15'h0000, a}, 16'h0001, "read ack");
    chk({15'h0000, e}, {15'h0000, c == 8'h33}, "read refusal");
  endtask

  // Bounded wait for the rail level; the count is checked against a window
  task automatic wait_reg(input logic lvl, input int lo, input int hi);
    int n;
    n = 0;
    while (reg_en !== lvl && n < 2000) begin
      @(negedge mclk_i);
      n++;
    end
    chk({15'h0000, (n >= lo && n <= hi)}, 16'h0001, "regulate timing");
    if (n >= 2000) tally_and_finish();
  endtask

  // Longer than any off delay in use, so a wrong transition would show
  task automatic hold(input logic lvl);
    repeat (60) @(negedge mclk_i);
    chk({15'h0000, reg_en}, {15'h0000, lvl}, "regulate level");
  endtask

  initial begin
    repeat (16) @(negedge mclk_i);
    chk({4'h0, ref_o}, 16'h00B3, "reference in reset");
    rst_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    chk({4'h0, ref_o}, 16'h0200, "reference after reset");
    $display("reset test done");
    foreach (rows[i]) begin
      wr_cmd(rows[i].c, rows[i].d, re);
      chk({15'h0000, re}, {15'h0000, rows[i].e}, "refusal");
      rd_cmd(rows[i].c, rv);
      chk(rv, rows[i].rb, "readback");
    end
    $display("register table done");
    foreach (refs[i]) begin
      wr_cmd(refs[i].c, refs[i].d, re);
      @(negedge mclk_i);
      chk({4'h0, ref_o}, refs[i].rb, "reference");
    end
    $display("reference test done");
    // Lockout alone with 3 ms on and 2 ms off delay
    vin = 16'h0014;
    wait_reg(1'b1, 18, 45);
    vin = 16'h0011;
    hold(1'b1);
    vin = 16'h0010;
    wait_reg(1'b0, 8, 35);
    vin = 16'h0011;
    hold(1'b0);
    $display("lockout test done");
    wr_cmd(8'h02, 16'h000E, re);
    vin = 16'h0014;
    pin = 1'b1;
    hold(1'b0);
    wr_cmd(8'h01, 16'h0080, re);
    wait_reg(1'b1, 18, 45);
    pin = 1'b0;
    wait_reg(1'b0, 8, 37);
    pin = 1'b1;
    repeat (10) @(negedge mclk_i);
    pin = 1'b0;
    hold(1'b0);
    wr_cmd(8'h02, 16'h000C, re);
    wait_reg(1'b1, 18, 47);
    wr_cmd(8'h60, 16'h0000, re);
    wr_cmd(8'h01, 16'h0000, re);
    wait_reg(1'b0, 8, 35);
    wr_cmd(8'h01, 16'h0080, re);
    wait_reg(1'b1, 0, 6);
    $display("gating test done");
    // Sixteen samples 100..130 step 2 average to 115
    for (int i = 0; i < 16; i++) begin
      smp = 16'(100 + 2 * i);
      svld = 1'b1;
      @(negedge mclk_i);
      svld = 1'b0;
      @(negedge mclk_i);
    end
    rd_cmd(8'h8B, rv);
    chk(rv, 16'h0073, "average");
    wr_cmd(8'h8B, 16'h0000, re);
    chk({15'h0000, re}, 16'h0001, "measure write");
    $display("telemetry test done");
    rst_i = 1'b1;
    repeat (3) @(negedge mclk_i);
    chk({4'h0, ref_o}, 16'h00B3, "reference in reset");
    chk({15'h0000, reg_en}, 16'h0000, "rail in reset");
    rst_i = 1'b0;
    rd_cmd(8'h21, rv);
    chk(rv, 16'h0200, "target after reset");
    // Default config: lockout alone, zero delays; drop below every legal off threshold
    wait_reg(1'b1, 0, 6);
    vin = 16'h000F;
    wait_reg(1'b0, 0, 6);
    $display("second reset test done");
    tally_and_finish();
  end
endmodule
